// ### core/abmr_defs.vh
// Summary of operation
// RQ1 - low level asserts active-low pins
// RQ2 - request bus; drop on internal cancel
// RQ3 - request when unparked and work pending
// RQ4 - single-cycle request for zero/touch hits
// RQ5 - request off one cycle after grant
// RQ6 - request off after retry detected
// RQ7 - request negated cycle after retry
// RQ8 - grant qualified: busy, retry negated
// RQ9 - parked master takes grant without request
// RQ10 - owner samples grant after tenure completes
// RQ11 - ignore grant from start to acknowledge
// RQ12 - grant valid in preceding cycle counts
// RQ13 - drive busy while owning the bus
// RQ14 - aborted access declines qualified grant
// RQ15 - busy negated after address acknowledge
// RQ16 - release busy after driving it negated
// RQ17 - foreign busy blocks taking ownership
// RQ18 - others assert busy only when idle
// RQ19 - start with busy, negate next cycle
// RQ20 - rising-edge timing; reset negates outputs
`ifndef ABMR_DEFS_VH
`define ABMR_DEFS_VH

`define ABMR_ST_W 5
`define ABMR_ST_IDLE 5'h01
`define ABMR_ST_OWN 5'h02
`define ABMR_ST_TEN 5'h04
`define ABMR_ST_REL 5'h08
`define ABMR_ST_SPARE 5'h10

`define ABMR_BIT_IDLE 0
`define ABMR_BIT_OWN 1
`define ABMR_BIT_TEN 2
`define ABMR_BIT_REL 3

`define ABMR_CLK_PERIOD_PS 40000
`define ABMR_BUSY_NEG_MIN_PS 20000
`define ABMR_BUSY_NEG_CYC \
    ((`ABMR_BUSY_NEG_MIN_PS + `ABMR_CLK_PERIOD_PS - 1) / `ABMR_CLK_PERIOD_PS)
`define ABMR_REQ_GAP_CYC 1

`define ABMR_PIN_ASSERT 1'b0
`define ABMR_PIN_NEGATE 1'b1
`define ABMR_OE_DRIVE 1'b0
`define ABMR_OE_FLOAT 1'b1

`endif

// ### core/abmr_rst_sync.v
`timescale 1ns/1ps
module abmr_rst_sync (
    clk,
    resetn,
    rst_n
);
    input wire clk;
    input wire resetn;
    output wire rst_n;

    reg meta_ff;
    reg hold_ff;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            hold_ff <= meta_ff;
        end
    end

    assign rst_n = hold_ff;
endmodule

// ### core/abmr_qual.v
`timescale 1ns/1ps
`include "abmr_defs.vh"
module abmr_qual (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire grant_in_n,
    input wire addr_busy_in_n,
    input wire addr_retry_n,
    input wire addr_ack_n,
    input wire xfer_start_in_n,
    output wire grant_qual,
    output wire start_window
);
    reg window_ff;
    reg nxt_window;
    wire grant_on;
    wire busy_on;
    wire retry_on;
    wire ack_on;
    wire start_on;

    // pin levels to assertion sense
    assign grant_on = (grant_in_n == `ABMR_PIN_ASSERT); // RQ1
    assign busy_on = (addr_busy_in_n == `ABMR_PIN_ASSERT); // RQ1
    assign retry_on = (addr_retry_n == `ABMR_PIN_ASSERT);
    assign ack_on = (addr_ack_n == `ABMR_PIN_ASSERT);
    assign start_on = (xfer_start_in_n == `ABMR_PIN_ASSERT);

    // open from any start up to and including its acknowledge
    always @* begin
        nxt_window = window_ff;
        if (start_on) begin
            nxt_window = 1'b1;
        end else if (ack_on) begin
            nxt_window = 1'b0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            window_ff <= 1'b0;
        end else if (clk_en) begin
            window_ff <= nxt_window;
        end
    end

    assign start_window = window_ff | start_on | ack_on; // RQ11

    // pins sampled at this edge carry the previous cycle's grant
    assign grant_qual = grant_on & ~busy_on & ~retry_on & ~start_window; // RQ8 RQ12 RQ17
endmodule

// ### core/abmr_top.v
`timescale 1ns/1ps
`include "abmr_defs.vh"
module abmr_top #(
    parameter REQ_GAP = `ABMR_REQ_GAP_CYC,
    parameter BUSY_NEG = `ABMR_BUSY_NEG_CYC,
    parameter CNT_W = 4
) (
    input wire clk,
    input wire resetn,
    input wire clk_en,
    input wire parked,
    input wire xact_pending,
    input wire xact_cancel,
    input wire single_req,
    input wire grant_in_n,
    input wire addr_busy_in_n,
    input wire addr_retry_n,
    input wire addr_ack_n,
    input wire xfer_start_in_n,
    output wire bus_request_n,
    output wire addr_busy_out_n,
    output wire addr_busy_oe_n,
    output wire xfer_start_out_n,
    output wire xfer_start_oe_n,
    output wire bus_owner,
    output wire tenure_start,
    output wire tenure_done,
    output wire tenure_retry
);
    localparam [`ABMR_ST_W-1:0] ST_IDLE = `ABMR_ST_IDLE;
    localparam [`ABMR_ST_W-1:0] ST_OWN = `ABMR_ST_OWN;
    localparam [`ABMR_ST_W-1:0] ST_TEN = `ABMR_ST_TEN;
    localparam [`ABMR_ST_W-1:0] ST_REL = `ABMR_ST_REL;
    localparam [31:0] GAP_LOAD_FULL = REQ_GAP - 1;
    localparam [31:0] NEG_LOAD_FULL = BUSY_NEG - 1;
    localparam [CNT_W-1:0] GAP_LOAD = GAP_LOAD_FULL[CNT_W-1:0];
    localparam [CNT_W-1:0] NEG_LOAD = NEG_LOAD_FULL[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    wire rst_n;
    wire grant_qual;
    wire start_window;
    wire retry_on;
    wire ack_on;
    wire want;
    wire may_sample;
    wire accept;
    wire st_idle;
    wire st_own;
    wire st_ten;
    wire st_rel;
    wire req_blocked;

    reg [`ABMR_ST_W-1:0] state_ff;
    reg [`ABMR_ST_W-1:0] nxt_state;
    reg req_ff;
    reg nxt_req;
    reg [CNT_W-1:0] gap_ff;
    reg [CNT_W-1:0] nxt_gap;
    reg [CNT_W-1:0] neg_ff;
    reg [CNT_W-1:0] nxt_neg;
    reg busy_drv_ff;
    reg nxt_busy_drv;
    reg busy_oe_ff;
    reg nxt_busy_oe;
    reg start_drv_ff;
    reg nxt_start_drv;
    reg start_oe_ff;
    reg nxt_start_oe;
    reg owner_ff;
    reg nxt_owner;
    reg start_pulse_ff;
    reg done_pulse_ff;
    reg retry_pulse_ff;

    abmr_rst_sync u_rst_sync (
        .clk(clk),
        .resetn(resetn),
        .rst_n(rst_n)
    );

    abmr_qual u_qual (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .grant_in_n(grant_in_n),
        .addr_busy_in_n(addr_busy_in_n),
        .addr_retry_n(addr_retry_n),
        .addr_ack_n(addr_ack_n),
        .xfer_start_in_n(xfer_start_in_n),
        .grant_qual(grant_qual),
        .start_window(start_window)
    );

    assign st_idle = state_ff[`ABMR_BIT_IDLE];
    assign st_own = state_ff[`ABMR_BIT_OWN];
    assign st_ten = state_ff[`ABMR_BIT_TEN];
    assign st_rel = state_ff[`ABMR_BIT_REL];

    assign retry_on = (addr_retry_n == `ABMR_PIN_ASSERT); // RQ1
    assign ack_on = (addr_ack_n == `ABMR_PIN_ASSERT);

    // work that still wants the bus
    assign want = xact_pending & ~xact_cancel; // RQ2

    // owner looks for a grant only once its tenure has completed
    assign may_sample = st_idle | (st_rel & (neg_ff == CNT_ZERO)); // RQ10

    // parked: no request needed; else only if our request stood
    assign accept = grant_qual & may_sample & want
                  & (parked | req_ff); // RQ9 RQ14

    // request hold-off after an accepted grant or a retry
    assign req_blocked = accept | retry_on | (gap_ff != CNT_ZERO); // RQ5 RQ6 RQ7

    // tenure sequencer
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_OWN; // RQ13
                end
            end
            ST_OWN: begin
                if (ack_on) begin
                    nxt_state = ST_REL;
                end else begin
                    nxt_state = ST_TEN;
                end
            end
            ST_TEN: begin
                if (ack_on) begin
                    nxt_state = ST_REL; // RQ15
                end
            end
            ST_REL: begin
                if (accept) begin
                    nxt_state = ST_OWN;
                end else if (neg_ff == CNT_ZERO) begin
                    nxt_state = ST_IDLE; // RQ16
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // bus request level
    always @* begin
        nxt_req = 1'b0;
        if (single_req) begin
            nxt_req = 1'b1; // RQ4
        end
        if (want & ~parked & ~st_own) begin
            nxt_req = 1'b1; // RQ3
        end
        if (req_blocked) begin
            nxt_req = 1'b0; // RQ5 RQ7
        end
    end

    always @* begin
        nxt_gap = gap_ff;
        if (accept | retry_on) begin
            nxt_gap = GAP_LOAD; // RQ6
        end else if (gap_ff != CNT_ZERO) begin
            nxt_gap = gap_ff - CNT_ONE;
        end
    end

    // driven-negated time for busy after acknowledge
    always @* begin
        nxt_neg = neg_ff;
        if ((st_ten | st_own) & ack_on) begin
            nxt_neg = NEG_LOAD; // RQ15
        end else if (neg_ff != CNT_ZERO) begin
            nxt_neg = neg_ff - CNT_ONE;
        end
    end

    // busy pin drive and enable
    always @* begin
        nxt_busy_drv = `ABMR_PIN_NEGATE;
        nxt_busy_oe = `ABMR_OE_FLOAT;
        case (nxt_state)
            ST_OWN: begin
                nxt_busy_drv = `ABMR_PIN_ASSERT; // RQ13
                nxt_busy_oe = `ABMR_OE_DRIVE;
            end
            ST_TEN: begin
                nxt_busy_drv = `ABMR_PIN_ASSERT; // RQ13
                nxt_busy_oe = `ABMR_OE_DRIVE;
            end
            ST_REL: begin
                nxt_busy_drv = `ABMR_PIN_NEGATE; // RQ15
                nxt_busy_oe = `ABMR_OE_DRIVE;
            end
            default: begin
                nxt_busy_drv = `ABMR_PIN_NEGATE;
                nxt_busy_oe = `ABMR_OE_FLOAT; // RQ16 RQ18
            end
        endcase
    end

    // start pin: one cycle with busy, floats when busy negates
    always @* begin
        nxt_start_drv = `ABMR_PIN_NEGATE;
        nxt_start_oe = `ABMR_OE_FLOAT;
        case (nxt_state)
            ST_OWN: begin
                nxt_start_drv = `ABMR_PIN_ASSERT; // RQ19
                nxt_start_oe = `ABMR_OE_DRIVE;
            end
            ST_TEN: begin
                nxt_start_drv = `ABMR_PIN_NEGATE; // RQ19
                nxt_start_oe = `ABMR_OE_DRIVE;
            end
            default: begin
                nxt_start_drv = `ABMR_PIN_NEGATE;
                nxt_start_oe = `ABMR_OE_FLOAT;
            end
        endcase
    end

    always @* begin
        nxt_owner = 1'b0;
        if (nxt_state == ST_OWN) begin
            nxt_owner = 1'b1;
        end
        if (nxt_state == ST_TEN) begin
            nxt_owner = 1'b1;
        end
    end

    // state registers, all frozen while clk_en is low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            gap_ff <= CNT_ZERO;
            neg_ff <= CNT_ZERO;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            gap_ff <= nxt_gap;
            neg_ff <= nxt_neg;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ff <= 1'b0; // RQ20
        end else if (clk_en) begin
            req_ff <= nxt_req; // RQ20
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_drv_ff <= `ABMR_PIN_NEGATE; // RQ20
            busy_oe_ff <= `ABMR_OE_FLOAT;
            start_drv_ff <= `ABMR_PIN_NEGATE;
            start_oe_ff <= `ABMR_OE_FLOAT;
        end else if (clk_en) begin
            busy_drv_ff <= nxt_busy_drv;
            busy_oe_ff <= nxt_busy_oe;
            start_drv_ff <= nxt_start_drv;
            start_oe_ff <= nxt_start_oe;
        end
    end

    // status toward the core
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            owner_ff <= 1'b0;
            start_pulse_ff <= 1'b0;
            done_pulse_ff <= 1'b0;
            retry_pulse_ff <= 1'b0;
        end else if (clk_en) begin
            owner_ff <= nxt_owner;
            start_pulse_ff <= accept;
            done_pulse_ff <= (st_own | st_ten) & ack_on;
            retry_pulse_ff <= st_rel & (neg_ff == CNT_ZERO) & retry_on;
        end
    end

    assign bus_request_n = ~req_ff; // RQ1
    assign addr_busy_out_n = busy_drv_ff;
    assign addr_busy_oe_n = busy_oe_ff;
    assign xfer_start_out_n = start_drv_ff;
    assign xfer_start_oe_n = start_oe_ff;
    assign bus_owner = owner_ff;
    assign tenure_start = start_pulse_ff;
    assign tenure_done = done_pulse_ff;
    assign tenure_retry = retry_pulse_ff;
endmodule

// ### test/abmr_chk.sv
`timescale 1ns/1ps
module abmr_chk (
    input wire clk,
    input wire resetn,
    input wire parked,
    input wire xact_cancel,
    input wire addr_busy_in_n,
    input wire addr_retry_n,
    input wire addr_ack_n,
    input wire xfer_start_in_n,
    input wire bus_request_n,
    input wire addr_busy_out_n,
    input wire addr_busy_oe_n,
    input wire xfer_start_out_n,
    input wire xfer_start_oe_n,
    input wire tenure_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire own_busy = !addr_busy_oe_n && !addr_busy_out_n;
    chk_req_after_grant: assert property (tenure_start |-> bus_request_n)
        else $error("request held at grant");
    chk_req_after_retry: assert property (!addr_retry_n |=> bus_request_n)
        else $error("request after retry");
    chk_start_with_busy: assert property (tenure_start |-> own_busy && !xfer_start_out_n)
        else $error("busy or start missing");
    chk_start_one_cycle: assert property ((!xfer_start_oe_n && !xfer_start_out_n)
        |=> xfer_start_out_n && !xfer_start_oe_n)
        else $error("start not one cycle");
    chk_busy_release: assert property ((own_busy && !addr_ack_n)
        |=> (addr_busy_out_n && !addr_busy_oe_n && xfer_start_oe_n)
        ##1 (addr_busy_oe_n || tenure_start))
        else $error("busy release order");
    chk_foreign_busy: assert property ((!addr_busy_in_n && addr_busy_oe_n) |=> !tenure_start)
        else $error("took bus while busy");
    chk_retry_qual: assert property (!addr_retry_n |=> !tenure_start)
        else $error("took bus during retry");
    chk_start_window: assert property (!xfer_start_in_n |=> !tenure_start)
        else $error("grant taken in window");
    chk_cancel_decl: assert property (xact_cancel |=> !tenure_start)
        else $error("cancelled access took bus");
    chk_no_request: assert property ((!parked && bus_request_n) |=> !tenure_start)
        else $error("took bus unrequested");
    chk_owner_no_grant: assert property (own_busy |=> !tenure_start)
        else $error("owner took new grant");
endmodule

bind abmr_top abmr_chk abmr_chk_i (.clk(clk), .resetn(resetn), .parked(parked),
    .xact_cancel(xact_cancel), .addr_busy_in_n(addr_busy_in_n), .addr_retry_n(addr_retry_n),
    .addr_ack_n(addr_ack_n), .xfer_start_in_n(xfer_start_in_n),
    .bus_request_n(bus_request_n), .addr_busy_out_n(addr_busy_out_n),
    .addr_busy_oe_n(addr_busy_oe_n), .xfer_start_out_n(xfer_start_out_n),
    .xfer_start_oe_n(xfer_start_oe_n), .tenure_start(tenure_start));

// ### test/abmr_far_end.sv
`timescale 1ns/1ps
module abmr_far_end (
    input wire clk,
    input wire bus_request_n,
    input wire addr_busy_oe_n,
    input wire xfer_start_in_n,
    input wire park_grant,
    input wire retry_on,
    input wire block_on,
    output logic grant_in_n,
    output logic addr_ack_n,
    output logic addr_retry_n,
    output logic busy_other_n
);
    int wait_cnt;
    logic acked;
    initial begin
        grant_in_n = 1'b1;
        addr_ack_n = 1'b1;
        addr_retry_n = 1'b1;
        busy_other_n = 1'b1;
        wait_cnt = 0;
        acked = 1'b0;
    end
    always @(posedge clk) begin
        grant_in_n <= !(park_grant || !bus_request_n);
        addr_retry_n <= !(acked && retry_on);
        busy_other_n <= !(block_on && addr_busy_oe_n && (grant_in_n || !busy_other_n));
        addr_ack_n <= 1'b1;
        acked <= 1'b0;
        if (!xfer_start_in_n) begin
            wait_cnt <= 1 + $urandom_range(3);
        end else if (wait_cnt == 1) begin
            addr_ack_n <= 1'b0;
            acked <= 1'b1;
            wait_cnt <= 0;
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

// ### test/address_bus_mastership_requester_tb_top.sv
`timescale 1ns/1ps
module address_bus_mastership_requester_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic parked = 1'b0;
    logic xact_pending = 1'b0;
    logic xact_cancel = 1'b0;
    logic single_req = 1'b0;
    logic park_grant = 1'b0;
    logic retry_on = 1'b0;
    logic block_on = 1'b0;
    wire grant_in_n, addr_retry_n, addr_ack_n, busy_other_n, bus_request_n, addr_busy_out_n;
    wire addr_busy_oe_n, xfer_start_out_n, xfer_start_oe_n, bus_owner, tenure_start;
    wire tenure_done, tenure_retry;
    wire addr_busy_in_n = (addr_busy_oe_n ? 1'b1 : addr_busy_out_n) & busy_other_n;
    wire xfer_start_in_n = xfer_start_oe_n ? 1'b1 : xfer_start_out_n;
    int bad_count = 0;
    int total_checks = 0;
    int n_start = 0;
    int n_retry = 0;
    int n_done = 0;
    int s0;
    abmr_top abmr_top_i (.clk(clk), .resetn(resetn), .clk_en(clk_en), .parked(parked),
        .xact_pending(xact_pending), .xact_cancel(xact_cancel), .single_req(single_req),
        .grant_in_n(grant_in_n), .addr_busy_in_n(addr_busy_in_n), .addr_retry_n(addr_retry_n),
        .addr_ack_n(addr_ack_n), .xfer_start_in_n(xfer_start_in_n),
        .bus_request_n(bus_request_n), .addr_busy_out_n(addr_busy_out_n),
        .addr_busy_oe_n(addr_busy_oe_n), .xfer_start_out_n(xfer_start_out_n),
        .xfer_start_oe_n(xfer_start_oe_n), .bus_owner(bus_owner), .tenure_start(tenure_start),
        .tenure_done(tenure_done), .tenure_retry(tenure_retry));
    abmr_far_end abmr_far_end_i (.clk(clk), .bus_request_n(bus_request_n),
        .addr_busy_oe_n(addr_busy_oe_n), .xfer_start_in_n(xfer_start_in_n),
        .park_grant(park_grant), .retry_on(retry_on), .block_on(block_on),
        .grant_in_n(grant_in_n), .addr_ack_n(addr_ack_n), .addr_retry_n(addr_retry_n),
        .busy_other_n(busy_other_n));
    initial begin
        forever #20 clk = !clk;
    end
    always @(posedge clk) begin
        if (tenure_start === 1'b1) n_start++;
        if (tenure_retry === 1'b1) n_retry++;
        if (tenure_done === 1'b1) n_done++;
    end
    function automatic logic exp_req(input logic pk, input logic pd, input logic cn);
        return !(!pk && pd && !cn);
    endfunction
    task automatic chk(input string nm, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_start;
        int i;
        i = 0;
        while (tenure_start !== 1'b1 && i < 40) begin
            @(negedge clk);
            i++;
        end
        chk("tenure_start", 1'b1, tenure_start);
    endtask
    task automatic go_idle;
        int i;
        @(posedge clk);
        xact_pending <= 1'b0;
        parked <= 1'b0;
        park_grant <= 1'b0;
        retry_on <= 1'b0;
        i = 0;
        cyc(2);
        while (addr_busy_oe_n !== 1'b1 && i < 40) begin
            @(negedge clk);
            i++;
        end
        chk("busy float", 1'b1, addr_busy_oe_n);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        end_sim;
    end
    initial begin
        void'($urandom(53095));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        cyc(3);
        chk("bus_request_n", 1'b1, bus_request_n);
        chk("addr_busy_oe_n", 1'b1, addr_busy_oe_n);
        $display("test reset done");
        @(posedge clk);
        xact_pending <= 1'b1;
        cyc(2);
        chk("request", exp_req(1'b0, 1'b1, 1'b0), bus_request_n);
        wait_start;
        chk("busy drive", 1'b0, addr_busy_out_n);
        chk("start drive", 1'b0, xfer_start_out_n);
        chk("request drop", 1'b1, bus_request_n);
        chk("owner", 1'b1, bus_owner);
        cyc(1);
        chk("start negate", 1'b1, xfer_start_out_n);
        go_idle;
        chk("walk done", 1'b1, n_done == n_start);
        $display("test walk done");
        s0 = n_start;
        @(posedge clk);
        parked <= 1'b1;
        park_grant <= 1'b1;
        xact_pending <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            chk("parked request", 1'b1, bus_request_n);
        end
        chk("parked tenure", 1'b1, n_start > s0);
        go_idle;
        $display("test parked done");
        @(posedge clk);
        single_req <= 1'b1;
        @(posedge clk);
        single_req <= 1'b0;
        clk_en <= 1'b0;
        cyc(1);
        chk("single on", 1'b0, bus_request_n);
        cyc(3);
        chk("frozen request", 1'b0, bus_request_n);
        @(posedge clk);
        clk_en <= 1'b1;
        cyc(2);
        chk("single off", 1'b1, bus_request_n);
        $display("test single done");
        @(posedge clk);
        block_on <= 1'b1;
        xact_pending <= 1'b1;
        cyc(3);
        chk("blocked request", 1'b0, bus_request_n);
        chk("blocked owner", 1'b0, bus_owner);
        @(posedge clk);
        xact_cancel <= 1'b1;
        cyc(2);
        chk("cancel request", exp_req(1'b0, 1'b1, 1'b1), bus_request_n);
        @(posedge clk);
        block_on <= 1'b0;
        park_grant <= 1'b1;
        cyc(8);
        chk("cancel owner", 1'b0, bus_owner);
        @(posedge clk);
        xact_cancel <= 1'b0;
        wait_start;
        go_idle;
        $display("test cancel done");
        s0 = n_retry;
        @(posedge clk);
        retry_on <= 1'b1;
        xact_pending <= 1'b1;
        wait_start;
        cyc(12);
        chk("retry seen", 1'b1, n_retry > s0);
        go_idle;
        $display("test retry done");
        s0 = n_start;
        for (int k = 0; k < 400; k++) begin
            @(posedge clk);
            parked <= ($urandom % 4) == 0;
            xact_pending <= ($urandom % 4) != 0;
            xact_cancel <= ($urandom % 16) == 0;
            single_req <= ($urandom % 16) == 0;
            park_grant <= ($urandom % 3) == 0;
            retry_on <= ($urandom % 4) == 0;
            block_on <= ($urandom % 8) == 0;
        end
        @(posedge clk);
        xact_cancel <= 1'b0;
        single_req <= 1'b0;
        block_on <= 1'b0;
        go_idle;
        chk("random tenures", 1'b1, n_start > s0);
        chk("done count", 1'b1, n_done == n_start);
        $display("test random done");
        end_sim;
    end
endmodule
